// File: logic/mdc_pkg.sv
// mdc_pkg: constants, types and decoders of the
// multiply/divide co-processor.
// assumes one 20 MHz system clock and the core's sfr bus.
`default_nettype none
package mdc_pkg;
  // sfr byte addresses
  localparam logic [7:0] ADDR_BYTE0 = 8'he9;
  localparam logic [7:0] ADDR_BYTE1 = 8'hea;
  localparam logic [7:0] ADDR_BYTE2 = 8'heb;
  localparam logic [7:0] ADDR_BYTE3 = 8'hec;
  localparam logic [7:0] ADDR_BYTE4 = 8'hed;
  localparam logic [7:0] ADDR_BYTE5 = 8'hee;
  localparam logic [7:0] ADDR_ARC = 8'hef;
  // control/status field positions
  localparam int ARC_ERR_BIT = 7;
  localparam int ARC_OV_BIT = 6;
  localparam int ARC_DIR_BIT = 5;
  localparam int ARC_SC_MSB = 4;
  // reset values
  localparam logic [7:0] ARC_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // execution cycles
  localparam logic [5:0] CYC_DIV32 = 6'h11;
  localparam logic [5:0] CYC_DIV16 = 6'h09;
  localparam logic [5:0] CYC_MUL = 6'h0b;
  localparam logic [5:0] CYC_SHIFT_BASE = 6'h02;
  localparam logic [5:0] CYC_NORM_BASE = 6'h03;
  // product limit before overflow
  localparam logic [31:0] MUL_LIMIT = 32'h0000ffff;

  // operation chosen by the write order
  typedef enum logic [2:0] {
    OP_NONE, OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT, OP_NORM
  } mdc_op_t;

  // pending result of a launched calculation
  typedef struct packed {
    logic [47:0] data;
    logic ov;
    logic [4:0] sc;
  } mdc_res_t;

  // true when the address is one of the six byte registers
  function automatic logic is_byte(input logic [7:0] a);
    return (a >= ADDR_BYTE0) && (a <= ADDR_BYTE5);
  endfunction

  // index 0..5 of a byte register address
  function automatic logic [2:0] byte_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_BYTE0;
    return d[2:0];
  endfunction
endpackage
`default_nettype wire

// File: logic/mdc_coproc.sv
// mdc_coproc: unsigned multiply/divide/shift co-processor
// on the core's special function register bus.
// assumes strobes and address come from logic on clk_i.
//
// Contract
// - all arithmetic is unsigned
// - six bytes hold operands, overwritten by results
// - runs alone, core never stalled
// - seven registers: six bytes plus control
// - bit 7 flags restarted or interrupted operation
// - bit 6 flags arithmetic overflow
// - zero count normalizes, returns shift count
// - nonzero count shifts by that amount
// - write order alone picks the operation
// - byte 0 write opens every sequence
// - byte 5 or control write launches
// - byte 2/3 written selects 32/16 divide
// - byte 4 last: divide, byte 1: multiply
// - bit 5 sets direction, zeros fill
// - fixed execution cycles for divide and multiply, shift and normalize cycles by shift count
// - byte access or control write while busy sets error; control read clears
// - overflow on zero divisor, big product, normalized
`timescale 1ns/100ps
`default_nettype none
module mdc_coproc (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sfr bus from the core
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  // read data, one cycle after the read strobe
  output logic [7:0] sfr_rdata_o,
  // calculation running
  output logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // load sequence tracker
  typedef enum logic {SQ_IDLE, SQ_LOAD} mdc_seq_t;
  mdc_seq_t seq_reg;
  logic seen1_reg; // byte 1 written
  logic seen23_reg; // byte 2 or 3 written
  logic seen4_reg; // byte 4 written
  logic [2:0] last_reg; // last byte index written
  // register file
  logic [7:0] md_reg [6];
  logic err_reg;
  logic ov_reg;
  logic dir_reg; // 1 shifts right
  logic [4:0] sc_reg;
  // execution state
  logic [5:0] cnt_reg;
  mdc_pkg::mdc_op_t op_reg;
  mdc_pkg::mdc_res_t res_reg;
  logic armed_reg; // error mechanism enabled
  // bus decode
  logic wr_byte;
  logic wr_arc;
  logic wr_any;
  logic rd_byte;
  logic rd_arc;
  logic [2:0] idx;
  logic done;
  assign idx = mdc_pkg::byte_idx(sfr_addr_i);
  // six bytes and one control register
  assign wr_byte = sfr_wr_i && mdc_pkg::is_byte(sfr_addr_i);
  assign wr_arc = sfr_wr_i && (sfr_addr_i == mdc_pkg::ADDR_ARC);
  assign wr_any = wr_byte || wr_arc;
  assign rd_byte = sfr_rd_i && mdc_pkg::is_byte(sfr_addr_i);
  assign rd_arc = sfr_rd_i && (sfr_addr_i == mdc_pkg::ADDR_ARC);
  // a write during execution aborts, so no result then
  assign done = busy_o && (cnt_reg == 6'h00) && !wr_any;
  // operation decode from the write order
  mdc_pkg::mdc_op_t launch_op;
  always_comb begin
    launch_op = mdc_pkg::OP_NONE;
    // no opcode register, only the order counts
    if (seq_reg == SQ_LOAD) begin
      if (wr_byte && idx == 3'h5) begin
        // byte 5 write launches divide or multiply
        if (seen23_reg && seen1_reg && seen4_reg && last_reg == 3'h4) begin
          launch_op = mdc_pkg::OP_DIV32;
        end else if (!seen23_reg && seen1_reg && seen4_reg) begin
          // last of byte 4 or byte 1 decides
          if (last_reg == 3'h4) begin
            launch_op = mdc_pkg::OP_DIV16;
          end else if (last_reg == 3'h1) begin
            launch_op = mdc_pkg::OP_MUL;
          end
        end
      end else if (wr_arc) begin
        // control write launches shift or normalize
        if (seen1_reg && seen23_reg && !seen4_reg && last_reg == 3'h3) begin
          if (sfr_wdata_i[mdc_pkg::ARC_SC_MSB:0] == 5'h00) begin
            launch_op = mdc_pkg::OP_NORM;
          end else begin
            launch_op = mdc_pkg::OP_SHIFT;
          end
        end
      end
      // any other order leaves launch_op at none
    end
  end
  // sequence tracker: byte 0 opens, launch or mismatch closes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_reg <= SQ_IDLE;
      seen1_reg <= 1'b0;
      seen23_reg <= 1'b0;
      seen4_reg <= 1'b0;
      last_reg <= 3'h0;
    end else if (wr_byte && idx == 3'h0) begin
      // byte 0 always starts a new load sequence
      seq_reg <= SQ_LOAD;
      seen1_reg <= 1'b0;
      seen23_reg <= 1'b0;
      seen4_reg <= 1'b0;
      last_reg <= 3'h0;
    end else if ((wr_byte && idx == 3'h5) || wr_arc) begin
      // closing write, launched or not
      seq_reg <= SQ_IDLE;
    end else if (wr_byte && seq_reg == SQ_LOAD) begin
      last_reg <= idx;
      if (idx == 3'h1) begin
        seen1_reg <= 1'b1;
      end
      if (idx == 3'h2 || idx == 3'h3) begin
        seen23_reg <= 1'b1;
      end
      if (idx == 3'h4) begin
        seen4_reg <= 1'b1;
      end
    end
  end
  // operand views, byte 5 taken from the bus on its launch
  logic [31:0] num32;
  logic [15:0] den16;
  logic [15:0] num16;
  logic [15:0] mul_b;
  always_comb begin
    num32 = {md_reg[3], md_reg[2], md_reg[1], md_reg[0]};
    num16 = {md_reg[1], md_reg[0]};
    den16 = {sfr_wdata_i, md_reg[4]};
    mul_b = {sfr_wdata_i, md_reg[4]};
  end
  // leading zero count for normalize
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    n = 5'h1f; // all-zero input shifts the full range
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        n = 5'(31 - i);
      end
    end
    return n;
  endfunction
  // result and cycle count of the operation being launched
  mdc_pkg::mdc_res_t calc;
  logic [5:0] cyc;
  logic [31:0] prod;
  logic [4:0] nz;
  logic [4:0] amt;
  always_comb begin
    // plain unsigned operators, no signed mode
    calc = '0;
    cyc = 6'h00;
    prod = 32'(num16) * 32'(mul_b);
    nz = lead_zeros(num32);
    amt = sfr_wdata_i[mdc_pkg::ARC_SC_MSB:0];
    calc.sc = sc_reg;
    unique case (launch_op)
      mdc_pkg::OP_DIV32: begin
        cyc = mdc_pkg::CYC_DIV32;
        if (den16 == 16'h0000) begin
          calc.ov = 1'b1;
          calc.data = {num32[15:0], 32'hffffffff};
        end else begin
          calc.data = {16'(num32 % 32'(den16)), num32 / 32'(den16)};
        end
      end
      mdc_pkg::OP_DIV16: begin
        cyc = mdc_pkg::CYC_DIV16;
        if (den16 == 16'h0000) begin
          calc.ov = 1'b1;
          calc.data = {num16, md_reg[3], md_reg[2], 16'hffff};
        end else begin
          calc.data = {num16 % den16, md_reg[3], md_reg[2], num16 / den16};
        end
      end
      mdc_pkg::OP_MUL: begin
        cyc = mdc_pkg::CYC_MUL;
        calc.ov = prod > mdc_pkg::MUL_LIMIT;
        calc.data = {sfr_wdata_i, md_reg[4], prod};
      end
      mdc_pkg::OP_SHIFT: begin
        // two positions a cycle, so a count of 31 still ends in 18
        cyc = mdc_pkg::CYC_SHIFT_BASE + ((6'(amt) + 6'h01) >> 1);
        calc.sc = amt;
        if (sfr_wdata_i[mdc_pkg::ARC_DIR_BIT]) begin
          calc.data = {md_reg[5], md_reg[4], num32 >> amt};
        end else begin
          calc.data = {md_reg[5], md_reg[4], num32 << amt};
        end
      end
      mdc_pkg::OP_NORM: begin
        // top bit already set counts as overflow
        calc.ov = num32[31];
        calc.sc = num32[31] ? 5'h00 : nz;
        cyc = mdc_pkg::CYC_NORM_BASE + ((6'(calc.sc) + 6'h01) >> 1);
        calc.data = {md_reg[5], md_reg[4], num32 << calc.sc};
      end
      default: begin
        calc.data = {md_reg[5], md_reg[4], num32};
      end
    endcase
  end
  // execution timer; the core is never held meanwhile
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      cnt_reg <= 6'h00;
      op_reg <= mdc_pkg::OP_NONE;
      res_reg <= '0;
    end else if (launch_op != mdc_pkg::OP_NONE) begin
      // launch and let the core go on
      busy_o <= 1'b1;
      cnt_reg <= cyc - 6'h01;
      op_reg <= launch_op;
      res_reg <= calc;
    end else if (busy_o && wr_any) begin
      // interrupted: result dropped, flagged as error
      busy_o <= 1'b0;
    end else if (done) begin
      busy_o <= 1'b0;
    end else if (busy_o) begin
      cnt_reg <= cnt_reg - 6'h01;
    end
  end
  // byte registers: bus writes, results on completion
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_byte
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          md_reg[g] <= mdc_pkg::BYTE_RESET;
        end else if (wr_byte && idx == 3'(g)) begin
          md_reg[g] <= sfr_wdata_i; // operands in
        end else if (done) begin
          md_reg[g] <= res_reg.data[8*g +: 8];
        end
      end
    end
  endgenerate
  // direction and count: software writes, normalize returns count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_reg <= mdc_pkg::ARC_RESET[mdc_pkg::ARC_DIR_BIT];
      sc_reg <= mdc_pkg::ARC_RESET[mdc_pkg::ARC_SC_MSB:0];
    end else if (wr_arc) begin
      dir_reg <= sfr_wdata_i[mdc_pkg::ARC_DIR_BIT];
      sc_reg <= sfr_wdata_i[mdc_pkg::ARC_SC_MSB:0];
    end else if (done && op_reg == mdc_pkg::OP_NORM) begin
      sc_reg <= res_reg.sc;
    end
  end
  // overflow: hardware only, set or cleared by each completed operation
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_reg <= mdc_pkg::ARC_RESET[mdc_pkg::ARC_OV_BIT];
    end else if (done) begin
      ov_reg <= res_reg.ov;
    end
  end
  // error mechanism: opened by byte 0, closed by final read
  logic final_rd;
  assign final_rd = rd_byte && !busy_o &&
    (idx == ((op_reg == mdc_pkg::OP_DIV32 || op_reg == mdc_pkg::OP_DIV16) ? 3'h5 : 3'h3));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
    end else if (wr_byte && idx == 3'h0) begin
      armed_reg <= 1'b1;
    end else if (final_rd) begin
      armed_reg <= 1'b0; // last read ends the operation
    end
  end

  // error flag; a set in the clearing cycle wins
  logic err_set;
  assign err_set = busy_o && (wr_any || (rd_byte && armed_reg));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_reg <= mdc_pkg::ARC_RESET[mdc_pkg::ARC_ERR_BIT];
    end else if (err_set) begin
      err_reg <= 1'b1;
    end else if (rd_arc) begin
      err_reg <= 1'b0;
    end
  end

  // read mux, registered; unmapped addresses read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (rd_arc) begin
      sfr_rdata_o <= {err_reg, ov_reg, dir_reg, sc_reg};
    end else if (rd_byte) begin
      // a read while busy shows the operand, not the result
      sfr_rdata_o <= md_reg[idx];
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // checks
  chk_err_on_access: assert property (
    busy_o && wr_any |=> err_reg)
    else $error("access while busy did not set error");
  chk_err_read_clear: assert property (
    rd_arc && !busy_o ##1 !busy_o |-> !err_reg)
    else $error("control read did not clear error");
  chk_err_sticky: assert property (
    err_reg && !rd_arc |=> err_reg)
    else $error("error flag dropped without control read");
  chk_div32_cycles: assert property (
    launch_op == mdc_pkg::OP_DIV32 |=> busy_o && cnt_reg == 6'h10)
    else $error("32/16 divide does not take 17 cycles");
  chk_mul_cycles: assert property (
    launch_op == mdc_pkg::OP_MUL |=> busy_o && cnt_reg == 6'h0a)
    else $error("multiply does not take 11 cycles");
  chk_div16_cycles: assert property (
    launch_op == mdc_pkg::OP_DIV16 |=> busy_o && cnt_reg == 6'h08)
    else $error("16/16 divide does not take 9 cycles");
  chk_shift_cycles: assert property (
    launch_op == mdc_pkg::OP_SHIFT |=> busy_o && cnt_reg >= 6'h02 && cnt_reg <= 6'h11)
    else $error("shift does not take 3 to 18 cycles");
  chk_read_no_abort: assert property (
    busy_o && rd_byte && !wr_any && cnt_reg != 6'h00 |=> busy_o)
    else $error("read aborted the calculation");
  chk_mul_overflow: assert property (
    done && op_reg == mdc_pkg::OP_MUL |=> ov_reg == ({md_reg[3], md_reg[2]} != 16'h0000))
    else $error("multiply overflow does not match product");
  chk_norm_result: assert property (
    done && op_reg == mdc_pkg::OP_NORM && !res_reg.ov |=>
    md_reg[3][7] || {md_reg[3], md_reg[2], md_reg[1], md_reg[0]} == 32'h0)
    else $error("normalize left a leading zero");
  chk_stray_no_launch: assert property (
    seq_reg == SQ_IDLE && !busy_o |=> !busy_o)
    else $error("launch without a byte 0 sequence");
  chk_div_zero: assert property (
    launch_op == mdc_pkg::OP_DIV32 && den16 == 16'h0 |=> res_reg.ov)
    else $error("zero divisor not flagged");

  cov_div32: cover property (launch_op == mdc_pkg::OP_DIV32 ##[1:20] done);
  cov_mul: cover property (launch_op == mdc_pkg::OP_MUL ##[1:20] done);
  cov_norm: cover property (launch_op == mdc_pkg::OP_NORM ##[1:40] done);
  cov_err: cover property (busy_o && wr_any);
endmodule
`default_nettype wire

// File: dv/mdc_core_model.sv
// mdc_core_model: behavioural processor core on the sfr bus.
// assumes one clock; the bench calls its tasks in sequence.
`timescale 1ns/100ps
`default_nettype none
module mdc_core_model (
  // clock
  input wire logic clk_i,
  // sfr bus towards the co-processor
  output logic [7:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i
);
  // idle bus from time zero
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_wdata_o = 8'h00;
  end

  // one write; the bench orders them so byte 0 opens a sequence
  // released fields are inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    sfr_addr_o = a;
    sfr_wdata_o = d;
    sfr_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    sfr_wr_o = 1'b0;
    sfr_addr_o = ~a;
    sfr_wdata_o = ~d;
  endtask

  // one read; data is registered at the strobe edge, taken just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    sfr_addr_o = a;
    sfr_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    sfr_rd_o = 1'b0;
    sfr_addr_o = ~a;
    d = sfr_rdata_i;
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// tb_top: self-checking bench of the multiply/divide co-processor.
// assumes the core model drives the sfr bus; 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i;
  logic rst_i;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic busy;
  int miscompares = 0;
  int n_tests = 0;

  // dut and the core in front of it
  mdc_coproc u_mdc_coproc (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr),
    .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata), .busy_o(busy));
  mdc_core_model u_mdc_core_model (.clk_i(clk_i), .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr),
    .sfr_rd_o(sfr_rd), .sfr_wdata_o(sfr_wdata), .sfr_rdata_i(sfr_rdata));

  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // address of byte i, control is index 6
  function automatic logic [7:0] ba(input int i);
    return mdc_pkg::ADDR_BYTE0 + 8'(i);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      miscompares++;
    end
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    u_mdc_core_model.wr(ba(i), d);
  endtask

  task automatic rd(input int i, output logic [7:0] d);
    u_mdc_core_model.rd(ba(i), d);
  endtask

  // counts busy cycles after a launch, bounded against a hang
  task automatic wait_busy(output int n);
    n = 0;
    while (busy === 1'b1 && n < 64) begin
      n++;
      @(posedge clk_i);
      #1;
    end
  endtask

  // reads bytes 0..3; byte 3 last so it ends a product or shift
  task automatic rd32(output logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      rd(i, v[8*i +: 8]);
    end
  endtask

  task automatic t_reset();
    logic [7:0] d;
    rd(6, d);
    check(d, mdc_pkg::ARC_RESET, "control reset");
    rd(0, d);
    check(d, 8'h00, "byte0 reset");
    u_mdc_core_model.rd(8'h00, d);
    check(d, 8'h00, "unmapped read");
  endtask

  task automatic t_mul(input logic [15:0] x, input logic [15:0] y);
    logic [31:0] p;
    logic [31:0] v;
    logic [7:0] c;
    int n;
    p = {16'h0000, x} * {16'h0000, y};
    wr(0, x[7:0]);
    wr(4, y[7:0]);
    wr(1, x[15:8]);
    wr(5, y[15:8]);
    wait_busy(n);
    check(32'(n), 32'd11, "mul cycles");
    rd32(v);
    check(v, p, "product");
    rd(6, c);
    check(c[7:6], {1'b0, p > mdc_pkg::MUL_LIMIT}, "mul flags");
  endtask

  task automatic t_div16(input logic [15:0] x, input logic [15:0] y);
    logic [31:0] v;
    logic [7:0] c;
    int n;
    wr(0, x[7:0]);
    wr(1, x[15:8]);
    wr(4, y[7:0]);
    wr(5, y[15:8]);
    wait_busy(n);
    check(32'(n), 32'd9, "div16 cycles");
    rd(0, v[7:0]);
    rd(1, v[15:8]);
    rd(4, v[23:16]);
    rd(5, v[31:24]);
    check(v, (y == 16'h0000) ? {x, 16'hffff} : {x % y, x / y}, "div16 result");
    rd(6, c);
    check(c[6], y == 16'h0000, "div16 ov");
  endtask

  task automatic t_div32(input logic [31:0] x, input logic [15:0] y);
    logic [31:0] v;
    logic [15:0] r;
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(i, x[8*i +: 8]);
    end
    wr(4, y[7:0]);
    wr(5, y[15:8]);
    wait_busy(n);
    check(32'(n), 32'd17, "div32 cycles");
    rd32(v);
    rd(4, r[7:0]);
    rd(5, r[15:8]);
    check(v, x / {16'h0000, y}, "div32 quotient");
    check({16'h0000, r}, x % {16'h0000, y}, "div32 remainder");
  endtask

  // shift or normalize: value, control write, expected value and control, cycle bounds
  task automatic t_shift(input logic [31:0] x, input logic [7:0] ctl, input logic [31:0] ev,
    input logic [7:0] ec, input int lo, input int hi);
    logic [31:0] v;
    logic [7:0] c;
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(i, x[8*i +: 8]);
    end
    wr(6, ctl);
    wait_busy(n);
    check(32'(n >= lo && n <= hi), 32'd1, "shift cycles");
    rd32(v);
    check(v, ev, "shift value");
    rd(6, c);
    check(c, ec, "shift control");
  endtask

  task automatic t_err();
    logic [31:0] v;
    logic [7:0] c;
    int n;
    wr(0, 8'h02);
    wr(4, 8'h03);
    wr(1, 8'h00);
    wr(5, 8'h00);
    rd(0, c);
    wait_busy(n);
    rd32(v);
    check(v, 32'h00000006, "read while busy keeps run");
    rd(6, c);
    check(c[7], 1'b1, "error after busy read");
    rd(6, c);
    check(c[7], 1'b0, "error cleared by control read");
    wr(0, 8'h02);
    wr(4, 8'h03);
    wr(1, 8'h00);
    wr(5, 8'h00);
    wr(0, 8'h07);
    check(busy, 1'b0, "write aborts run");
    rd(6, c);
    check(c[7], 1'b1, "error after restart");
  endtask

  task automatic t_bad();
    logic [7:0] d;
    wr(0, 8'h11);
    wr(5, 8'h22);
    check(busy, 1'b0, "no launch");
    @(posedge clk_i);
    #1;
    check(busy, 1'b0, "still idle");
    rd(0, d);
    check(d, 8'h11, "byte0 kept");
    u_mdc_core_model.rd(8'h00, d);
    check(d, 8'h00, "unmapped read after data");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: the tests need well under 2000 cycles
  initial begin
    #(20000 * 50);
    miscompares++;
    complete_run();
  end

  // main sequence
  initial begin
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_mul(16'h1234, 16'h0056);
    t_mul(16'hffff, 16'hffff);
    t_div16(16'h1234, 16'h0056);
    t_div16(16'hbeef, 16'h0000);
    t_div32(32'h89abcdef, 16'h1234);
    t_shift(32'h80000001, 8'h24, 32'h08000000, 8'h24, 3, 18);
    t_shift(32'h80000001, 8'hc1, 32'h00000002, 8'h01, 3, 3);
    t_shift(32'h40000000, 8'h00, 32'h80000000, 8'h01, 4, 4);
    t_shift(32'h80000000, 8'h00, 32'h80000000, 8'h40, 0, 19);
    t_shift(32'h80000000, 8'h3f, 32'h00000001, 8'h3f, 18, 18);
    t_shift(32'h00000001, 8'h00, 32'h80000000, 8'h1f, 19, 19);
    t_err();
    t_bad();
    complete_run();
  end
endmodule
`default_nettype wire
